/* File: gcs_mux.sv */
`timescale 1ns/1ps
// What this block does
// (RQ1) protected switchover never emits a shortened high or low output pulse
// (RQ2) both clock inputs handled identically, either may be primary
// (RQ3) with protection off the new input is routed at once
// (RQ4) strap tied high disables protection for good, plain two-to-one selector
// (RQ5) protected handover completes within 17 new-clock cycles
// (RQ6) follow old clock, hold low for new pulses, then follow new
// (RQ7) old stuck high: hold high for new pulses, go low, then follow
// (RQ8) old stuck low: stay low for new falling edges, then follow
// (RQ9) selected input lost, protection on and no handover running: output frozen at last valid level
// (RQ10) select and clocks synchronised into this domain before use
module gcs_mux (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire gcs_pkg::gcs_pins_t pins,
  output logic clk_out,
  output gcs_pkg::gcs_status_t status
);

  // ==========================================================
  // pin synchronisers
  logic [gcs_pkg::NUM_PINS-1:0] pins_raw;
  logic [gcs_pkg::NUM_PINS-1:0] lvl_vec;
  gcs_pkg::gcs_pins_t lvl;
  gcs_pkg::gcs_pins_t prev;
  logic [gcs_pkg::NUM_PINS-1:0] prev_q;

  assign pins_raw = pins;

  // one synchroniser per pin
  genvar g;
  generate
    for (g = 0; g < gcs_pkg::NUM_PINS; g++) begin : g_sync
      gcs_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in(pins_raw[g]),
        .level(lvl_vec[g]) // RQ10
      );
    end
  endgenerate

  assign lvl = lvl_vec;
  assign prev = prev_q;

  // input selection, same for either side
  function automatic logic pick_clk(input gcs_pkg::gcs_pins_t p, input logic idx);
    pick_clk = idx ? p.clk_b : p.clk_a; // RQ2
  endfunction : pick_clk

  function automatic logic pick_lost(input gcs_pkg::gcs_pins_t p, input logic idx);
    pick_lost = idx ? p.lost_b : p.lost_a;
  endfunction : pick_lost

  // ==========================================================
  // strap capture
  logic [2:0] settle_q;
  logic [2:0] settle_d;
  logic bypass_q;
  logic bypass_d;

  // strap caught once, after the synchroniser has settled
  always_comb begin
    settle_d = settle_q;
    bypass_d = bypass_q;
    if (settle_q != gcs_pkg::STRAP_SETTLE) begin
      settle_d = settle_q + 3'h1;
      if (settle_d == gcs_pkg::STRAP_SETTLE) begin
        bypass_d = lvl.strap; // RQ4
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      settle_q <= gcs_pkg::SETTLE_RST;
      bypass_q <= gcs_pkg::BYPASS_RST;
    end else begin
      settle_q <= settle_d;
      bypass_q <= bypass_d;
    end
  end

  // ==========================================================
  // handover state machine
  gcs_pkg::gcs_state_t state_q;
  gcs_pkg::gcs_state_t state_d;
  logic cur_q;
  logic cur_d;
  logic out_q;
  logic out_d;
  logic [gcs_pkg::CNT_W-1:0] cnt_q;
  logic [gcs_pkg::CNT_W-1:0] cnt_d;
  logic old_lvl;
  logic new_rise;
  logic new_fall;

  assign old_lvl = pick_clk(lvl, cur_q);
  assign new_rise = pick_clk(lvl, ~cur_q) && !pick_clk(prev, ~cur_q);
  assign new_fall = !pick_clk(lvl, ~cur_q) && pick_clk(prev, ~cur_q);

  // next state, source and output level
  always_comb begin
    state_d = state_q;
    cur_d = cur_q;
    out_d = out_q;
    cnt_d = cnt_q;
    unique case (state_q)
      gcs_pkg::GCS_FOLLOW: begin
        if (bypass_q) begin
          cur_d = lvl.sel; // RQ3
          out_d = pick_clk(lvl, lvl.sel);
        end else if (lvl.sel != cur_q) begin
          state_d = gcs_pkg::GCS_DRAIN; // RQ6
          cnt_d = gcs_pkg::CNT_RST;
          out_d = old_lvl;
        end else if (!pick_lost(lvl, cur_q)) begin
          out_d = old_lvl;
        end // RQ9
      end
      gcs_pkg::GCS_DRAIN: begin
        if (!old_lvl) begin
          state_d = gcs_pkg::GCS_HOLD_LOW; // RQ8
          cnt_d = gcs_pkg::CNT_RST;
          out_d = 1'b0;
        end else if (new_rise && (cnt_q == gcs_pkg::STUCK_RISES - 5'h01)) begin
          state_d = gcs_pkg::GCS_HOLD_LOW; // RQ7
          cnt_d = gcs_pkg::CNT_RST;
          out_d = 1'b0;
        end else begin
          out_d = 1'b1; // RQ6
          if (new_rise) begin
            cnt_d = cnt_q + 5'h01;
          end
        end
      end
      gcs_pkg::GCS_HOLD_LOW: begin
        out_d = 1'b0;
        if (new_fall) begin
          if (cnt_q == gcs_pkg::HOLD_FALLS - 5'h01) begin // RQ5
            state_d = gcs_pkg::GCS_FOLLOW; // RQ1
            cur_d = ~cur_q;
            cnt_d = gcs_pkg::CNT_RST;
          end else begin
            cnt_d = cnt_q + 5'h01;
          end
        end
      end
      default: begin
        state_d = gcs_pkg::GCS_FOLLOW;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= gcs_pkg::GCS_FOLLOW;
      cur_q <= gcs_pkg::SRC_RST;
      out_q <= gcs_pkg::OUT_RST;
      cnt_q <= gcs_pkg::CNT_RST;
      prev_q <= gcs_pkg::PINS_RST;
    end else begin
      state_q <= state_d;
      cur_q <= cur_d;
      out_q <= out_d;
      cnt_q <= cnt_d;
      prev_q <= lvl_vec;
    end
  end

  // ==========================================================
  // outputs
  assign clk_out = bypass_q ? pick_clk(lvl, lvl.sel) : out_q; // RQ4
  assign status.busy = (state_q != gcs_pkg::GCS_FOLLOW);
  assign status.active_src = cur_q;
  assign status.bypass = bypass_q;

  // ==========================================================
  // checks
  logic [gcs_pkg::CNT_W-1:0] sw_edges_q;

  // new-clock rises counted across one handover
  always_ff @(posedge ref_clk) begin
    if (!rst_n || state_q == gcs_pkg::GCS_FOLLOW) begin
      sw_edges_q <= gcs_pkg::CNT_RST;
    end else if (new_rise && sw_edges_q != 5'h1f) begin
      sw_edges_q <= sw_edges_q + 5'h01;
    end
  end

  property p_no_rise_in_switch;
    @(posedge ref_clk) disable iff (!rst_n)
      (!bypass_q && state_q != gcs_pkg::GCS_FOLLOW && $past(state_q) != gcs_pkg::GCS_FOLLOW)
        |-> !(out_q && !$past(out_q));
  endproperty
  a_no_rise_in_switch: assert property (p_no_rise_in_switch) // RQ1
    else $error("output rose during handover");

  property p_handover_swaps_source;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_q == gcs_pkg::GCS_HOLD_LOW && state_d == gcs_pkg::GCS_FOLLOW)
        |=> (cur_q != $past(cur_q)) && !out_q;
  endproperty
  a_handover_swaps_source: assert property (p_handover_swaps_source) // RQ2
    else $error("handover did not swap to the other input");

  property p_bypass_immediate;
    @(posedge ref_clk) disable iff (!rst_n)
      bypass_q |-> (clk_out == (lvl.sel ? lvl.clk_b : lvl.clk_a)) && state_q == gcs_pkg::GCS_FOLLOW
        && (!$past(bypass_q) || cur_q == $past(lvl.sel));
  endproperty
  a_bypass_immediate: assert property (p_bypass_immediate) // RQ3
    else $error("bypass output not the selected input");

  property p_strap_sticky;
    @(posedge ref_clk) disable iff (!rst_n)
      (settle_q == gcs_pkg::STRAP_SETTLE) |=> $stable(bypass_q);
  endproperty
  a_strap_sticky: assert property (p_strap_sticky) // RQ4
    else $error("bypass changed after capture");

  property p_switch_bound;
    @(posedge ref_clk) disable iff (!rst_n)
      sw_edges_q <= gcs_pkg::MAX_SWITCH_EDGES;
  endproperty
  a_switch_bound: assert property (p_switch_bound) // RQ5
    else $error("handover exceeded its cycle bound");

  property p_drain_follows_old;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_q == gcs_pkg::GCS_DRAIN && old_lvl && !new_rise) |=> out_q;
  endproperty
  a_drain_follows_old: assert property (p_drain_follows_old) // RQ6
    else $error("output dropped while old clock high");

  property p_stuck_high_drop;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_q == gcs_pkg::GCS_DRAIN && old_lvl && new_rise && cnt_q == 5'h01)
        |=> state_q == gcs_pkg::GCS_HOLD_LOW && !out_q;
  endproperty
  a_stuck_high_drop: assert property (p_stuck_high_drop) // RQ7
    else $error("stuck-high old clock not released");

  property p_hold_low;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_q == gcs_pkg::GCS_HOLD_LOW) |-> !clk_out;
  endproperty
  a_hold_low: assert property (p_hold_low) // RQ8
    else $error("output not low during hold");

  property p_lost_freeze;
    @(posedge ref_clk) disable iff (!rst_n)
      (!bypass_q && state_q == gcs_pkg::GCS_FOLLOW && lvl.sel == cur_q && pick_lost(lvl, cur_q))
        |=> $stable(out_q);
  endproperty
  a_lost_freeze: assert property (p_lost_freeze) // RQ9
    else $error("output moved while input lost");

  property p_sel_starts_switch;
    @(posedge ref_clk) disable iff (!rst_n)
      (!bypass_q && state_q == gcs_pkg::GCS_FOLLOW && lvl.sel != cur_q)
        |=> state_q == gcs_pkg::GCS_DRAIN;
  endproperty
  a_sel_starts_switch: assert property (p_sel_starts_switch) // RQ10
    else $error("select change did not start handover");

endmodule : gcs_mux

/* File: gcs_pkg.sv */
// ==========================================================
// shared constants and carriers for the switchover mux
package gcs_pkg;

  // ==========================================================
  // widths and counts
  localparam int unsigned NUM_PINS = 6;
  localparam int unsigned CNT_W = 5;
  localparam logic [4:0] STUCK_RISES = 5'h02; // new-clock rises before old is taken as stuck high
  localparam logic [4:0] HOLD_FALLS = 5'h02; // new-clock falls spent low before following
  localparam logic [4:0] MAX_SWITCH_EDGES = 5'h11; // longest handover, in new-clock cycles
  localparam logic [2:0] STRAP_SETTLE = 3'h5; // cycles after reset before the strap is caught
  localparam logic [4:0] CNT_RST = 5'h00;
  localparam logic [2:0] SETTLE_RST = 3'h0;

  // ==========================================================
  // reset values
  localparam logic OUT_RST = 1'b0;
  localparam logic SRC_RST = 1'b0;
  localparam logic BYPASS_RST = 1'b0;
  localparam logic [NUM_PINS-1:0] PINS_RST = 6'h00;

  // ==========================================================
  // types
  typedef struct packed {
    logic lost_b;
    logic lost_a;
    logic strap;
    logic sel;
    logic clk_b;
    logic clk_a;
  } gcs_pins_t;

  typedef struct packed {
    logic busy;
    logic active_src;
    logic bypass;
  } gcs_status_t;

  typedef enum logic [1:0] {
    GCS_FOLLOW,
    GCS_DRAIN,
    GCS_HOLD_LOW
  } gcs_state_t;

endpackage : gcs_pkg

/* File: gcs_src_model.sv */
`timescale 1ns/1ps
// ==========
// two free clock sources that can stop or lose signal
module gcs_src_model #(
  parameter int HALF_A = 8,
  parameter int HALF_B = 11
) (
  input wire logic ref_clk,
  input wire logic run_a,
  input wire logic run_b,
  input wire logic lost_a,
  input wire logic lost_b,
  output wire logic clk_a,
  output wire logic clk_b
);
  int cnt_a = 0;
  int cnt_b = 0;
  logic lvl_a = 1'b0;
  logic lvl_b = 1'b0;
  int cnt_j = 0;
  logic junk = 1'b0;
  // halves counted on falling edges, a stopped source keeps its level
  always @(negedge ref_clk) begin
    cnt_j <= (cnt_j + 1) % 3;
    if (cnt_j == 2) junk <= ~junk;
    if (run_a) begin
      cnt_a <= (cnt_a + 1) % HALF_A;
      if (cnt_a == HALF_A - 1) lvl_a <= ~lvl_a;
    end
    if (run_b) begin
      cnt_b <= (cnt_b + 1) % HALF_B;
      if (cnt_b == HALF_B - 1) lvl_b <= ~lvl_b;
    end
  end
  // a lost line shows a slow pattern that the pin filter lets through
  assign clk_a = lost_a ? junk : lvl_a;
  assign clk_b = lost_b ? ~junk : lvl_b;
endmodule : gcs_src_model

/* File: gcs_sync.sv */
`timescale 1ns/1ps
// ==========================================================
// three-flop synchroniser, level moves once stages two and three agree
module gcs_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic level
);

  logic ff1_q;
  logic ff2_q;
  logic ff3_q;
  logic lvl_q;
  logic lvl_d;

  // filter on the two settled stages
  always_comb begin
    lvl_d = lvl_q;
    if (ff2_q == ff3_q) begin
      lvl_d = ff3_q;
    end
  end

  // ==========================================================
  // synchroniser chain
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ff1_q <= 1'b0;
      ff2_q <= 1'b0;
      ff3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      ff1_q <= async_in;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;

endmodule : gcs_sync

/* File: glitchless_clock_switchover_mux_tb_top.sv */
`timescale 1ns/1ps
// ==========
// bench for the switchover mux
module glitchless_clock_switchover_mux_tb_top;
  localparam int HALF_A = 8;
  localparam int HALF_B = 11;
  localparam int MIN_HALF = 8;
  localparam int SW_BOUND = 17 * 2 * HALF_B + 8; // 17 new-clock cycles plus sync delay
  logic ref_clk = 1'b0, rst_n = 1'b0, sel = 1'b0, strap = 1'b0, lost_a = 1'b0;
  logic lost_b = 1'b0, run_a = 1'b1, run_b = 1'b1, mon_en = 1'b0, last_out = 1'b0;
  logic clk_a, clk_b, clk_out, v;
  gcs_pkg::gcs_pins_t pins;
  gcs_pkg::gcs_status_t status;
  int err_total = 0, comparisons = 0, seed = 64, run_len = 0, run_ok = 0, n = 0;

  // ==========
  // parts
  assign pins = {lost_b, lost_a, strap, sel, clk_b, clk_a};
  gcs_src_model #(.HALF_A(HALF_A), .HALF_B(HALF_B)) src (.ref_clk(ref_clk), .run_a(run_a),
    .run_b(run_b), .lost_a(lost_a), .lost_b(lost_b), .clk_a(clk_a), .clk_b(clk_b));
  gcs_mux DUT (.ref_clk(ref_clk), .rst_n(rst_n), .pins(pins), .clk_out(clk_out),
    .status(status));

  // clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // ==========
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic do_reset(input logic s);
    @(negedge ref_clk);
    rst_n = 1'b0;
    strap = s;
    mon_en = 1'b0;
    sel = 1'b0;
    repeat (10) @(negedge ref_clk);
    check(32'({status, clk_out}), 32'h0);
    rst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    check(32'(status.bypass), 32'(s));
  endtask : do_reset

  // select a source and count cycles until the handover is done
  task automatic handover(input logic s, output int k);
    k = 0;
    @(negedge ref_clk);
    sel = s;
    while (!(status.busy === 1'b0 && status.active_src === s) && k < SW_BOUND) begin
      @(negedge ref_clk);
      k++;
    end
    check(32'(k < SW_BOUND), 32'h1);
  endtask : handover

  // rising edges of output and chosen source must agree over a window
  task automatic follow(input logic s);
    int ro, rn;
    logic po, pn;
    ro = 0;
    rn = 0;
    po = clk_out;
    pn = s ? clk_b : clk_a;
    repeat (240) begin
      @(negedge ref_clk);
      if (clk_out === 1'b1 && po === 1'b0) ro++;
      if ((s ? clk_b : clk_a) === 1'b1 && pn === 1'b0) rn++;
      po = clk_out;
      pn = s ? clk_b : clk_a;
    end
    check(32'((ro - rn) * (ro - rn) <= 1 && rn > 8), 32'h1);
  endtask : follow

  // lose the chosen source and expect the output to stand still
  task automatic freeze(input logic s);
    int c;
    logic h;
    mon_en = 1'b0;
    if (s) lost_b = 1'b1;
    else lost_a = 1'b1;
    repeat (8) @(negedge ref_clk);
    h = clk_out;
    c = 0;
    repeat (60) begin
      @(negedge ref_clk);
      if (clk_out !== h) c++;
    end
    check(32'(c), 32'h0);
    lost_a = 1'b0;
    lost_b = 1'b0;
    repeat (30) @(negedge ref_clk);
    mon_en = 1'b1;
  endtask : freeze

  // runt watch: while enabled, each output level must last at least MIN_HALF cycles, the shorter input half period
  always @(negedge ref_clk) begin
    if (!mon_en) begin
      run_ok = 0;
      run_len = 0;
    end else if (clk_out !== last_out) begin
      if (run_ok != 0) check(32'(run_len >= MIN_HALF), 32'h1);
      run_ok = 1;
      run_len = 1;
    end else run_len++;
    last_out = clk_out;
  end

  // ==========
  // tests
  initial begin
    do_reset(1'b0);
    mon_en = 1'b1;
    follow(1'b0);
    handover(1'b1, n);
    follow(1'b1);
    handover(1'b0, n);
    follow(1'b0);
    $display("test running_switch finished");
    while (clk_a !== 1'b0) @(negedge ref_clk);
    while (clk_a !== 1'b1) @(negedge ref_clk);
    run_a = 1'b0;
    repeat (20) @(negedge ref_clk);
    handover(1'b1, n);
    follow(1'b1);
    freeze(1'b1);
    run_a = 1'b1;
    while (clk_b !== 1'b1) @(negedge ref_clk);
    while (clk_b !== 1'b0) @(negedge ref_clk);
    run_b = 1'b0;
    repeat (30) @(negedge ref_clk);
    handover(1'b0, n);
    follow(1'b0);
    run_b = 1'b1;
    $display("test stuck_source finished");
    freeze(1'b0);
    $display("test lost_signal finished");
    repeat (6) begin
      @(negedge ref_clk);
      sel = 1'($random(seed));
      repeat ($unsigned($random(seed)) % 64) @(negedge ref_clk);
    end
    repeat (8) @(negedge ref_clk);
    v = sel;
    handover(v, n);
    follow(v);
    $display("test random_select finished");
    do_reset(1'b1);
    handover(1'b1, n);
    check(32'(n <= 6), 32'h1);
    follow(1'b1);
    handover(1'b0, n);
    check(32'(n <= 6), 32'h1);
    follow(1'b0);
    $display("test bypass finished");
    conclude();
  end

  // watchdog
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    conclude();
  end
endmodule : glitchless_clock_switchover_mux_tb_top
